// >>> logic/ladder_ref_cfg.svh
// Offsets, field positions, reset values and level constants of the ladder reference control.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LADDER_REF_CFG_SVH
`define LADDER_REF_CFG_SVH

`define LADDER_REF_ADDR_W 4
`define LADDER_REF_CTRL_OFFSET 4'h0
`define LADDER_REF_CTRL_RESET 8'h00
`define LADDER_REF_UNMAPPED_READ 8'h00

`define LADDER_POWER_BIT 7
`define LADDER_PIN_OE_BIT 6
`define LADDER_RANGE_BIT 5
`define LADDER_SOURCE_BIT 4
`define LADDER_TAP_MSB 3
`define LADDER_TAP_LSB 0

`define LADDER_LEVEL_W 7
`define LADDER_LEVEL_OFF 7'h00
`define LADDER_HIGH_BASE 7'h18

`endif

// >>> logic/ladder_ref_pkg.sv
// Types shared by the ladder reference control and its pin steering.
// Assumes the constants header sits beside it in logic/.
`include "ladder_ref_cfg.svh"

package ladder_ref_pkg;

  typedef struct packed {
    logic ladder_power_enable;
    logic ladder_pin_output_enable;
    logic ladder_range_select;
    logic ladder_source_select;
    logic [3:0] ladder_tap_code;
  } ladder_ctrl_t;

  typedef struct packed {
    logic drive_value;
    logic drive_oe_b;
    logic analog_connect;
  } pin_ctrl_t;

endpackage

// >>> logic/ladder_pin_steer.sv
// Steering of the shared analog pin between the port driver and the reference level.
// Assumes the port logic supplies its direction bit (one means input) and its data latch.
`timescale 1ns/1ps
`include "ladder_ref_cfg.svh"

module ladder_pin_steer (
  input wire ladder_ref_pkg::ladder_ctrl_t ctrl_in,
  input wire logic port_a_pin2_direction_in,
  input wire logic port_a_pin2_data_in,
  output ladder_ref_pkg::pin_ctrl_t pin_out
);
  import ladder_ref_pkg::*;

  wire ref_on_pin;
  wire digital_off;

  assign ref_on_pin = ctrl_in.ladder_pin_output_enable; // RQ2
  assign digital_off = ref_on_pin | port_a_pin2_direction_in; // RQ3
  // One driver for the whole struct; the reference owning the pin parks the drive value low.
  assign pin_out = pin_ctrl_t'{drive_value: port_a_pin2_data_in & ~ref_on_pin, // RQ3
                               drive_oe_b: digital_off, // RQ3
                               analog_connect: ref_on_pin}; // RQ2

endmodule

// >>> logic/comparator_reference_control.sv
// Control register of the comparator reference ladder, its level code and pin steering.
// Assumes a register master with one-cycle strobes and synchronous port inputs on core_clk_in.
`timescale 1ns/1ps
`include "ladder_ref_cfg.svh"

// Behaviour
// RQ1: Top bit one powers the ladder; zero keeps it powered down.
// RQ2: Bit six one connects the reference to the shared pin; zero disconnects it.
// RQ3: Set bit six overrides the port pin two direction bit.
// RQ4: Range bit one: low range, level equals code over 24 of source.
// RQ5: Range bit zero: level equals quarter source plus code over 32.
// RQ6: Bit four one takes external reference pins; zero takes supply rails.
// RQ7: Low four bits are tap code zero to fifteen selecting one level.
// RQ8: Outputs update on the write edge; reads return every stored bit.
module comparator_reference_control #(
  parameter int ADDR_W = `LADDER_REF_ADDR_W
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic port_a_pin2_direction_in,
  input wire logic port_a_pin2_data_in,
  output ladder_ref_pkg::ladder_ctrl_t ladder_ctrl_out,
  output logic [`LADDER_LEVEL_W-1:0] comparator_reference_level_out,
  output ladder_ref_pkg::pin_ctrl_t shared_analog_pin_out
);
  import ladder_ref_pkg::*;

  ladder_ctrl_t ctrl_q;
  ladder_ctrl_t ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [`LADDER_LEVEL_W-1:0] level_q;
  logic [`LADDER_LEVEL_W-1:0] level_d;

  wire hit;
  wire ctrl_write;
  wire ctrl_read;
  wire [`LADDER_LEVEL_W-1:0] tap_ext;
  wire [`LADDER_LEVEL_W-1:0] low_level;
  wire [`LADDER_LEVEL_W-1:0] high_level;
  wire [`LADDER_LEVEL_W-1:0] ranged_level;

  // Address decode of the single control register.
  assign hit = (reg_addr_in == ADDR_W'(`LADDER_REF_CTRL_OFFSET));
  assign ctrl_write = reg_wr_in & hit;
  assign ctrl_read = reg_rd_in & hit;

  // Next register value takes the whole written byte.
  assign ctrl_d = ctrl_write ? ladder_ctrl_t'(reg_wdata_in) : ctrl_q; // RQ8

  // Read data stand for one cycle after the strobe, zero elsewhere.
  assign rdata_d = ctrl_read ? 8'(ctrl_q) :
                   (reg_rd_in ? `LADDER_REF_UNMAPPED_READ : 8'h00); // RQ8

  // Level in ninety-sixths of the source span.
  assign tap_ext = {3'h0, ctrl_d.ladder_tap_code}; // RQ7
  assign low_level = {1'b0, ctrl_d.ladder_tap_code, 2'h0}; // RQ4
  assign high_level = `LADDER_HIGH_BASE + tap_ext + {tap_ext[5:0], 1'b0}; // RQ5
  assign ranged_level = ctrl_d.ladder_range_select ? low_level : high_level;
  assign level_d = ctrl_d.ladder_power_enable ? ranged_level : `LADDER_LEVEL_OFF; // RQ1

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= ladder_ctrl_t'(`LADDER_REF_CTRL_RESET);
    end else begin
      ctrl_q <= ctrl_d; // RQ8
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_q <= `LADDER_LEVEL_OFF;
    end else begin
      level_q <= level_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign ladder_ctrl_out = ctrl_q; // RQ1 RQ6 RQ7
  assign comparator_reference_level_out = level_q;
  assign reg_rdata_out = rdata_q;

  ladder_pin_steer u_pin_steer (
    .ctrl_in(ctrl_q),
    .port_a_pin2_direction_in(port_a_pin2_direction_in),
    .port_a_pin2_data_in(port_a_pin2_data_in),
    .pin_out(shared_analog_pin_out)
  );

  default clocking cb @(posedge core_clk_in);
  endclocking

  default disable iff (!rst_b_in);

  sequence s_ctrl_write;
    reg_wr_in && (reg_addr_in == ADDR_W'(`LADDER_REF_CTRL_OFFSET));
  endsequence

  sequence s_ctrl_read;
    reg_rd_in && (reg_addr_in == ADDR_W'(`LADDER_REF_CTRL_OFFSET));
  endsequence

  sequence s_quiet_bus;
    !reg_wr_in && !reg_rd_in;
  endsequence

  property p_write_takes_byte;
    s_ctrl_write |=> (8'(ladder_ctrl_out) == $past(reg_wdata_in));
  endproperty
  a_write_takes_byte: assert property (p_write_takes_byte) // RQ8
    else $error("Control outputs did not take the written byte.");

  property p_read_returns_stored;
    s_ctrl_read |=> (reg_rdata_out == $past(8'(ladder_ctrl_out)));
  endproperty
  a_read_returns_stored: assert property (p_read_returns_stored) // RQ8
    else $error("Read data differ from the stored control byte.");

  property p_write_then_read_back;
    s_ctrl_write ##1 s_ctrl_read |=> (reg_rdata_out == $past(reg_wdata_in, 2));
  endproperty
  a_write_then_read_back: assert property (p_write_then_read_back) // RQ8
    else $error("Back to back read did not return the written byte.");

  property p_unmapped_reads_zero;
    (reg_rd_in && !hit) |=> (reg_rdata_out == `LADDER_REF_UNMAPPED_READ);
  endproperty
  a_unmapped_reads_zero: assert property (p_unmapped_reads_zero)
    else $error("Unmapped read returned nonzero data.");

  property p_rdata_only_after_read;
    !reg_rd_in |=> (reg_rdata_out == 8'h00);
  endproperty
  a_rdata_only_after_read: assert property (p_rdata_only_after_read)
    else $error("Read data stood without a read strobe.");

  property p_power_down_level;
    (s_ctrl_write and (reg_wdata_in[`LADDER_POWER_BIT] == 1'b0)) |=>
      (!ladder_ctrl_out.ladder_power_enable && comparator_reference_level_out == `LADDER_LEVEL_OFF);
  endproperty
  a_power_down_level: assert property (p_power_down_level) // RQ1
    else $error("Ladder level not off after power-down write.");

  property p_power_up_follows;
    (s_ctrl_write and (reg_wdata_in[`LADDER_POWER_BIT] == 1'b1)) |=> ladder_ctrl_out.ladder_power_enable;
  endproperty
  a_power_up_follows: assert property (p_power_up_follows) // RQ1
    else $error("Ladder not powered after enable write.");

  property p_pin_connect;
    ladder_ctrl_out.ladder_pin_output_enable == shared_analog_pin_out.analog_connect;
  endproperty
  a_pin_connect: assert property (p_pin_connect) // RQ2
    else $error("Reference pin connection differs from the output enable.");

  property p_override_direction;
    (ladder_ctrl_out.ladder_pin_output_enable && !port_a_pin2_direction_in) |->
      shared_analog_pin_out.drive_oe_b;
  endproperty
  a_override_direction: assert property (p_override_direction) // RQ3
    else $error("Port driver enabled while the reference owns the pin.");

  property p_low_range_level;
    (ladder_ctrl_out.ladder_power_enable && ladder_ctrl_out.ladder_range_select) |->
      (comparator_reference_level_out == {1'b0, ladder_ctrl_out.ladder_tap_code, 2'h0});
  endproperty
  a_low_range_level: assert property (p_low_range_level) // RQ4
    else $error("Low range level is not four ninety-sixths per step.");

  property p_high_range_level;
    (ladder_ctrl_out.ladder_power_enable && !ladder_ctrl_out.ladder_range_select) |->
      (comparator_reference_level_out == 7'(24 + 3 * ladder_ctrl_out.ladder_tap_code));
  endproperty
  a_high_range_level: assert property (p_high_range_level) // RQ5
    else $error("High range level is not a quarter plus three ninety-sixths per step.");

  property p_source_select;
    s_ctrl_write |=> (ladder_ctrl_out.ladder_source_select == $past(reg_wdata_in[`LADDER_SOURCE_BIT]));
  endproperty
  a_source_select: assert property (p_source_select) // RQ6
    else $error("Source select did not follow the write.");

  property p_tap_holds;
    s_quiet_bus ##1 s_quiet_bus |-> $stable(ladder_ctrl_out.ladder_tap_code);
  endproperty
  a_tap_holds: assert property (p_tap_holds) // RQ7
    else $error("Tap code changed without a write.");

  property p_ctrl_holds;
    !(reg_wr_in && hit) |=> $stable(ladder_ctrl_out);
  endproperty
  a_ctrl_holds: assert property (p_ctrl_holds) // RQ8
    else $error("Control outputs changed without a write to the register.");

  property p_level_off_when_down;
    !ladder_ctrl_out.ladder_power_enable |-> (comparator_reference_level_out == `LADDER_LEVEL_OFF);
  endproperty
  a_level_off_when_down: assert property (p_level_off_when_down) // RQ1
    else $error("Ladder level not off while powered down.");

  property p_pin_released;
    !ladder_ctrl_out.ladder_pin_output_enable |->
      (shared_analog_pin_out.drive_oe_b == port_a_pin2_direction_in &&
       shared_analog_pin_out.drive_value == port_a_pin2_data_in);
  endproperty
  a_pin_released: assert property (p_pin_released) // RQ2
    else $error("Port driver not restored while the reference is off the pin.");

  property p_ref_drive_quiet;
    ladder_ctrl_out.ladder_pin_output_enable |-> !shared_analog_pin_out.drive_value;
  endproperty
  a_ref_drive_quiet: assert property (p_ref_drive_quiet) // RQ3
    else $error("Port drive value not parked while the reference owns the pin.");

endmodule

// >>> dv/ladder_pin_model.sv
// Far-side model of the ladder and the shared pin wire.
// Assumes the control and pin structs of the ladder reference package.
`timescale 1ns/1ps

module ladder_pin_model (
  input wire ladder_ref_pkg::ladder_ctrl_t ctrl_in,
  input wire ladder_ref_pkg::pin_ctrl_t pin_in,
  output logic ladder_live_out,
  output logic pin_level_out
);
  import ladder_ref_pkg::*;
  // The ladder draws current only while powered.
  assign ladder_live_out = ctrl_in.ladder_power_enable;
  // Analog owns the wire when connected, else the port driver, else the pull-up.
  assign pin_level_out = pin_in.analog_connect ? ladder_live_out :
    (pin_in.drive_oe_b ? 1'b1 : pin_in.drive_value);
endmodule

// >>> dv/comparator_reference_control_tb_top.sv
// Self-checking bench of the comparator reference control register.
// Assumes the design files under logic/ and the pin model under dv/.
`timescale 1ns/1ps

module comparator_reference_control_tb_top;
  import ladder_ref_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dir = 1'b1;
  logic dat = 1'b0;
  logic [7:0] rdata;
  ladder_ctrl_t ctrl;
  logic [6:0] level;
  pin_ctrl_t pin;
  logic live;
  logic pin_lvl;
  int failures = 0;
  int num_checks = 0;
  logic [7:0] v;

  always #20 core_clk_in = ~core_clk_in;

  comparator_reference_control i_comparator_reference_control (.core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .port_a_pin2_direction_in(dir), .port_a_pin2_data_in(dat),
    .ladder_ctrl_out(ctrl), .comparator_reference_level_out(level), .shared_analog_pin_out(pin));
  ladder_pin_model i_ladder_pin_model (.ctrl_in(ctrl), .pin_in(pin), .ladder_live_out(live),
    .pin_level_out(pin_lvl));

  function automatic logic [7:0] exp_level(input logic [7:0] c);
    if (!c[7]) return 8'h00;
    return c[5] ? {2'h0, c[3:0], 2'h0} : 8'h18 + 8'(c[3:0]) * 8'h03;
  endfunction

  function automatic logic [7:0] exp_pin(input logic [7:0] c, input logic d, input logic x);
    return {5'h00, x & ~c[6], c[6] | d, c[6]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_in);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge core_clk_in);
    #1;
    chk(rdata, 8'h00);
  endtask

  task automatic wr_rd_reg(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge core_clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_in);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(40 * 4000);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(52));
    repeat (20) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    #1;
    chk(ctrl, 8'h00);
    rd_reg(4'h0, 8'h00);
    $display("reset test done");
    wr_reg(4'h0, 8'hE5);
    chk(ctrl, 8'hE5);
    chk(level, exp_level(8'hE5));
    rd_reg(4'h0, 8'hE5);
    wr_reg(4'h3, 8'h12);
    chk(ctrl, 8'hE5);
    rd_reg(4'h7, 8'h00);
    $display("walk test done");
    wr_rd_reg(4'h0, 8'h5A, 8'h5A);
    wr_rd_reg(4'h2, 8'hFF, 8'h00);
    chk(ctrl, 8'h5A);
    v = 8'($urandom);
    wr_rd_reg(4'h0, v, v);
    chk(level, exp_level(v));
    $display("back to back test done");
    for (int i = 0; i < 64; i++) begin
      v = {i[5], 1'($urandom_range(0, 1)), i[4], 1'($urandom_range(0, 1)), i[3:0]};
      wr_reg(4'h0, v);
      chk(ctrl, v);
      chk(level, exp_level(v));
      chk(live, v[7]);
      for (int k = 0; k < 4; k++) begin
        @(posedge core_clk_in);
        dir <= k[1];
        dat <= k[0];
        @(posedge core_clk_in);
        #1;
        chk(pin, exp_pin(v, k[1], k[0]));
        chk(pin_lvl, v[6] ? v[7] : (k[1] | k[0]));
      end
      if (i % 16 == 15) rd_reg(4'h0, v);
    end
    $display("sweep test done");
    @(posedge core_clk_in);
    rst_b_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    chk(ctrl, 8'h00);
    chk(level, 8'h00);
    chk(rdata, 8'h00);
    chk(pin, exp_pin(8'h00, dir, dat));
    @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    wr_rd_reg(4'h0, 8'hC3, 8'hC3);
    chk(level, exp_level(8'hC3));
    $display("reset again test done");
    summarize();
  end
endmodule
